/* File: src/wsw_watchdog_sleep_wake.sv */
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - External pin edge: rising when option bit 6 set, falling when clear.
// - A valid external edge sets the external flag, interrupt control bit 1.
// - External enable, bit 4, masks the edge interrupt and allows wake.
// - External flag may set anywhere in the phase 4 to phase 1 span.
// - Timer zero rolling FFh to 00h sets bit 2; enable bit 5.
// - Change on port B pins 7..4 sets bit 0; own enable gates it.
// - Taking an interrupt saves only the return program counter.
// - Watchdog counts on its own free-running time base, alive during sleep.
// - Expiry while running resets; expiry while asleep wakes and continues.
// - Clearing the fuse enable bit of the configuration word disables watchdog.
// - Nominal period 18 ms; assigned prescaler divides further up to 1:128.
// - Clear-watchdog or sleep clears watchdog count and assigned prescaler.
// - Clear-watchdog leaves prescaler assignment and ratio untouched.
// - Expiry clears the active-low timeout status bit.
// - Sleep entry: clear watchdog, power-down bit low, timeout high, oscillator off.
// - Pins keep their pre-sleep drive state during sleep.
// - Leave sleep by master reset (status bits kept), expiry or enabled interrupt.
// - Power-down bit set at power-up, cleared on sleep entry.
// - Only phase-clock-free peripheral interrupts may wake from sleep.
// - Wake needs flag and enable only, regardless of global enable.
// - After interrupt wake run prefetched instruction, then vector if global enable.
// - Flags are set by events whatever the enables say.
// - Taking interrupt clears global enable, pushes return address, jumps to 0004h.
// - Sleep with an enabled interrupt pending acts as a no-operation.
module wsw_watchdog_sleep_wake
	import wsw_pkg::*;
#(
	parameter int RC_DIV    = WSW_RC_DIV,
	parameter int WDT_TICKS = WSW_WDT_TICKS
)(
	// Clock and resets
	input  wire logic          sys_clk,
	input  wire logic          sys_rst,
	input  wire logic          masterResetN,
	// Configuration word strap, caught during reset
	input  wire logic [7:0]    cfgStrap,
	// Register bus
	input  wire wsw_avs_req_t  avsReq,
	output var  logic [31:0]   readdata,
	output var  logic          waitrequest,
	// Processor core
	input  wire wsw_core_req_t coreReq,
	output var  wsw_core_rsp_t coreRsp,
	// Interrupt sources
	input  wire logic          extIrqPin,
	input  wire logic [7:0]    timerZero,
	input  wire logic [7:0]    portBPins,
	input  wire logic [6:0]    periphIrq,
	// Pin drive from the port logic and to the pads
	input  wire logic [7:0]    pinOut,
	input  wire logic [7:0]    pinOe,
	output var  logic [7:0]    padOut,
	output var  logic [7:0]    padOe
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		wsw_mode_t   mode;
		logic [7:0]  option;
		logic [7:0]  irqCtl;
		logic [7:0]  cfg;
		logic        toN;
		logic        pdN;
		logic        oscEn;
		logic        primed;
		logic        extLast;
		logic [7:0]  tmrLast;
		logic [3:0]  portLast;
		logic [7:0]  padOut;
		logic [7:0]  padOe;
		logic        ack;
		logic [31:0] rdata;
		logic        wake;
		logic        wdtRst;
		logic        vector;
		logic [12:0] retPc;
	} wsw_state_t;

	wsw_state_t s;
	wsw_state_t next_s;

	logic       rcTick;
	logic       wdtExpire;
	logic       wdtClear;
	logic       extEdge;
	logic       tmrRoll;
	logic       portChange;
	logic       anyWake;
	logic       softRst;
	logic       sleepGo;
	logic       takeIrq;
	logic       busReq;
	logic       wrEn;
	logic [13:0] regIdx;

	// ************************************************************
	// Watchdog
	// ************************************************************
	wsw_rc_osc #(
		.RC_DIV (RC_DIV)
	) u_rc (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.rcTick  (rcTick)
	);

	wsw_wdt_counter #(
		.WDT_TICKS (WDT_TICKS)
	) u_wdt (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.rcTick     (rcTick),
		.fuseEnable (s.cfg[WSW_CFG_WDT_EN]),
		.clear      (wdtClear),
		.psaWdt     (s.option[WSW_OPT_PSA]),
		.psRatio    (s.option[2:0]),
		.expire     (wdtExpire)
	);

	// ************************************************************
	// Events and decisions
	// ************************************************************
	// Edge and change detectors wait one cycle after reset so a steady level is no event
	assign extEdge    = s.primed & (s.option[WSW_OPT_EDGE] ? (extIrqPin & ~s.extLast)
	                                                        : (~extIrqPin & s.extLast));
	assign tmrRoll    = s.primed & (s.tmrLast == WSW_TMR_MAX) & (timerZero == WSW_TMR_MIN);
	assign portChange = s.primed & (portBPins[7:4] != s.portLast);

	// Any source with flag and enable both set; the global enable plays no part
	assign anyWake = (s.irqCtl[WSW_IRQ_EXT_EN] & s.irqCtl[WSW_IRQ_EXT_F])
	               | (s.irqCtl[WSW_IRQ_TMR_EN] & s.irqCtl[WSW_IRQ_TMR_F])
	               | (s.irqCtl[WSW_IRQ_PB_EN] & s.irqCtl[WSW_IRQ_PB_F])
	               | (s.irqCtl[WSW_IRQ_PEIE] & (|periphIrq));

	// Expiry is a registered pulse of this domain; sys_clk keeps running in sleep, so none is lost
	assign softRst  = ~masterResetN | (wdtExpire & (s.mode != WSW_SLEEP));
	assign sleepGo  = coreReq.sleepInstr & (s.mode == WSW_RUN) & ~anyWake & ~softRst;
	assign wdtClear = coreReq.watchdog_clear_instr | sleepGo;
	assign takeIrq  = (s.mode == WSW_RUN) & s.irqCtl[WSW_IRQ_GIE] & anyWake & ~softRst;

	// Bus: every access is answered on its second cycle
	assign busReq      = avsReq.read | avsReq.write;
	assign waitrequest = busReq & ~s.ack;
	assign regIdx      = avsReq.address[15:2];
	assign wrEn        = avsReq.write & s.ack & avsReq.byteenable[0];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_s        = s;
		next_s.wake   = 1'b0;
		next_s.wdtRst = 1'b0;
		next_s.vector = 1'b0;

		// Detector history
		next_s.primed   = 1'b1;
		next_s.extLast  = extIrqPin;
		next_s.tmrLast  = timerZero;
		next_s.portLast = portBPins[7:4];

		// Bus handshake and read capture; unmapped reads return zero
		next_s.ack = busReq & ~s.ack;
		if (avsReq.read & ~s.ack) begin
			case (regIdx)
				WSW_IDX_OPTION: next_s.rdata = {24'h000000, s.option};
				WSW_IDX_IRQ:    next_s.rdata = {24'h000000, s.irqCtl};
				WSW_IDX_CONFIG: next_s.rdata = {24'h000000, s.cfg};
				WSW_IDX_STATUS: next_s.rdata = {27'h0000000, s.toN, s.pdN, 3'h0};
				default:        next_s.rdata = 32'h00000000;
			endcase
		end

		// Software writes; option change never touches the watchdog counts
		if (wrEn && regIdx == WSW_IDX_OPTION) begin
			next_s.option = avsReq.writedata[7:0];
		end
		if (wrEn && regIdx == WSW_IDX_IRQ) begin
			next_s.irqCtl = avsReq.writedata[7:0];
		end

		// Hardware sets win over a software clear in the same cycle
		if (extEdge) begin
			next_s.irqCtl[WSW_IRQ_EXT_F] = 1'b1;
		end
		if (tmrRoll) begin
			next_s.irqCtl[WSW_IRQ_TMR_F] = 1'b1;
		end
		if (portChange) begin
			next_s.irqCtl[WSW_IRQ_PB_F] = 1'b1;
		end

		// Interrupt response: only the return address goes to the stack
		if (takeIrq) begin
			next_s.irqCtl[WSW_IRQ_GIE] = 1'b0;
			next_s.vector              = 1'b1;
			next_s.retPc               = coreReq.pc;
		end

		// Sleep and wake sequencing
		case (s.mode)
			WSW_RUN: begin
				if (sleepGo) begin
					next_s.mode  = WSW_SLEEP;
					next_s.pdN   = 1'b0;
					next_s.toN   = 1'b1;
					next_s.oscEn = 1'b0;
				end
			end
			WSW_SLEEP: begin
				if (wdtExpire) begin
					next_s.mode  = WSW_RUN;
					next_s.toN   = 1'b0;
					next_s.oscEn = 1'b1;
					next_s.wake  = 1'b1;
				end else if (anyWake) begin
					next_s.mode  = WSW_WAKE;
					next_s.oscEn = 1'b1;
					next_s.wake  = 1'b1;
				end
			end
			WSW_WAKE: begin
				// Prefetched instruction runs first; the vector may follow from run mode
				if (coreReq.instrRetire) begin
					next_s.mode = WSW_RUN;
				end
			end
			default: begin
				next_s.mode = WSW_RUN;
			end
		endcase

		// Pads follow the port logic except while asleep, when they freeze
		if (next_s.mode != WSW_SLEEP) begin
			next_s.padOut = pinOut;
			next_s.padOe  = pinOe;
		end

		// Watchdog reset while running, or master reset at any time
		if (softRst) begin
			next_s.mode   = WSW_RUN;
			next_s.oscEn  = 1'b1;
			next_s.option = WSW_OPT_RESET;
			next_s.vector = 1'b0;
			next_s.wake   = 1'b0;
			next_s.padOut = pinOut;
			next_s.padOe  = pinOe;
			if (!masterResetN) begin
				next_s.irqCtl = WSW_IRQ_RESET;
			end else begin
				next_s.irqCtl = s.irqCtl & WSW_IRQ_WDT_KEEP;
				next_s.wdtRst = 1'b1;
				next_s.toN    = 1'b0;
				next_s.pdN    = 1'b1;
			end
		end

		// Power-up: the fuse strap is caught here, status bits start high
		if (sys_rst) begin
			next_s        = '0;
			next_s.mode   = WSW_RUN;
			next_s.option = WSW_OPT_RESET;
			next_s.irqCtl = WSW_IRQ_RESET;
			next_s.cfg    = cfgStrap;
			next_s.toN    = 1'b1;
			next_s.pdN    = 1'b1;
			next_s.oscEn  = 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		s <= next_s;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign readdata           = s.rdata;
	assign padOut             = s.padOut;
	assign padOe              = s.padOe;
	assign coreRsp.wakeUp     = s.wake;
	assign coreRsp.wdtReset   = s.wdtRst;
	assign coreRsp.irqVector  = s.vector;
	assign coreRsp.stackPush  = s.vector;
	assign coreRsp.oscEnable  = s.oscEn;
	assign coreRsp.sleeping   = (s.mode == WSW_SLEEP);
	assign coreRsp.vectorPc   = WSW_VECTOR;
	assign coreRsp.returnPc   = s.retPc;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence sleep_with_irq;
		(s.mode == WSW_SLEEP) && anyWake && !wdtExpire && masterResetN;
	endsequence

	sequence woken_by_irq;
		coreRsp.wakeUp && (s.mode == WSW_WAKE) && coreRsp.oscEnable;
	endsequence

	ext_flag_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(extEdge && !softRst) |=> s.irqCtl[WSW_IRQ_EXT_F])
		else $error("external flag missed an edge");
	tmr_flag_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s.tmrLast == WSW_TMR_MAX && timerZero == WSW_TMR_MIN && s.primed && !softRst)
		|=> s.irqCtl[WSW_IRQ_TMR_F])
		else $error("timer flag missed a rollover");
	port_flag_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s.primed && portBPins[7:4] != $past(portBPins[7:4]) && !softRst) |=> s.irqCtl[WSW_IRQ_PB_F])
		else $error("port change flag missed a change");
	sleep_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(coreReq.sleepInstr && s.mode == WSW_RUN && !anyWake && !softRst)
		|=> !s.pdN && s.toN && !coreRsp.oscEnable && coreRsp.sleeping)
		else $error("sleep entry status wrong");
	sleep_nop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(coreReq.sleepInstr && s.mode == WSW_RUN && anyWake && !softRst)
		|=> $stable(s.pdN) && $stable(s.toN) && !coreRsp.sleeping)
		else $error("sleep with pending interrupt was not a no-operation");
	wdt_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s.mode == WSW_SLEEP && wdtExpire && masterResetN)
		|=> coreRsp.wakeUp && !s.toN && coreRsp.oscEnable && !coreRsp.wdtReset && $stable(s.option))
		else $error("watchdog wake from sleep wrong");
	wdt_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s.mode != WSW_SLEEP && wdtExpire && masterResetN) |=> coreRsp.wdtReset && !s.toN && s.pdN)
		else $error("watchdog expiry did not reset");
	irq_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sleep_with_irq |=> woken_by_irq)
		else $error("enabled interrupt did not wake");
	irq_take_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		takeIrq |=> coreRsp.irqVector && coreRsp.stackPush && !s.irqCtl[WSW_IRQ_GIE]
		            && coreRsp.returnPc == $past(coreReq.pc))
		else $error("interrupt response wrong");
	wake_inline_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s.mode == WSW_WAKE) |=> !coreRsp.irqVector)
		else $error("vectored before the prefetched instruction");
	pin_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(coreRsp.sleeping && $past(coreRsp.sleeping)) |-> $stable(padOut) && $stable(padOe))
		else $error("pins moved during sleep");
	bus_answer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(busReq && waitrequest) |=> !waitrequest)
		else $error("bus answer late");

endmodule
`default_nettype wire

/* File: src/wsw_pkg.sv */
`default_nettype none
package wsw_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int WSW_SYS_CLK_NS        = 40;
	localparam int WSW_WDT_PERIOD_NS     = 18000000;
	localparam int WSW_WDT_PERIOD_CYCLES = WSW_WDT_PERIOD_NS / WSW_SYS_CLK_NS;
	localparam int WSW_RC_DIV            = 25;
	localparam int WSW_WDT_TICKS         = WSW_WDT_PERIOD_CYCLES / WSW_RC_DIV;
	localparam int WSW_CNT_W             = 16;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [13:0] WSW_IDX_STATUS = 14'h0003;
	localparam logic [13:0] WSW_IDX_IRQ    = 14'h000b;
	localparam logic [13:0] WSW_IDX_OPTION = 14'h0081;
	localparam logic [13:0] WSW_IDX_CONFIG = 14'h2007;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int WSW_OPT_EDGE   = 6;
	localparam int WSW_OPT_PSA    = 3;
	localparam int WSW_IRQ_GIE    = 7;
	localparam int WSW_IRQ_PEIE   = 6;
	localparam int WSW_IRQ_TMR_EN = 5;
	localparam int WSW_IRQ_EXT_EN = 4;
	localparam int WSW_IRQ_PB_EN  = 3;
	localparam int WSW_IRQ_TMR_F  = 2;
	localparam int WSW_IRQ_EXT_F  = 1;
	localparam int WSW_IRQ_PB_F   = 0;
	localparam int WSW_ST_TO      = 4;
	localparam int WSW_ST_PD      = 3;
	localparam int WSW_CFG_WDT_EN = 2;

	localparam logic [7:0]  WSW_OPT_RESET    = 8'hff;
	localparam logic [7:0]  WSW_IRQ_RESET    = 8'h00;
	localparam logic [7:0]  WSW_IRQ_WDT_KEEP = 8'h01;
	localparam logic [7:0]  WSW_TMR_MAX      = 8'hff;
	localparam logic [7:0]  WSW_TMR_MIN      = 8'h00;
	localparam logic [12:0] WSW_VECTOR       = 13'h0004;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {WSW_RUN, WSW_SLEEP, WSW_WAKE} wsw_mode_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [15:0] address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} wsw_avs_req_t;

	typedef struct packed {
		logic        watchdog_clear_instr;
		logic        sleepInstr;
		logic        instrRetire;
		logic [12:0] pc;
	} wsw_core_req_t;

	typedef struct packed {
		logic        wakeUp;
		logic        wdtReset;
		logic        irqVector;
		logic        stackPush;
		logic        oscEnable;
		logic        sleeping;
		logic [12:0] vectorPc;
		logic [12:0] returnPc;
	} wsw_core_rsp_t;

	// Mask of the watchdog prescaler for ratio 1:2^ps
	function automatic logic [6:0] wsw_ratio_mask(input logic [2:0] ps);
		return 7'((8'h01 << ps) - 8'h01);
	endfunction

endpackage
`default_nettype wire

/* File: src/wsw_rc_osc.sv */
`timescale 1ns/10ps
`default_nettype none
module wsw_rc_osc
	import wsw_pkg::*;
#(
	parameter int RC_DIV = WSW_RC_DIV
)(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// Watchdog time base
	output var  logic rcTick
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} wsw_rc_t;

	localparam logic [7:0] LAST = 8'(RC_DIV - 1);

	wsw_rc_t s;
	wsw_rc_t next_s;

	// Free-running divider: nothing but reset stops it, so sleep never halts the watchdog
	always_comb begin
		next_s      = s;
		next_s.tick = 1'b0;
		if (s.cnt == LAST) begin
			next_s.cnt  = 8'h00;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 8'h01;
		end
		if (sys_rst) begin
			next_s = '0;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		s <= next_s;
	end

	assign rcTick = s.tick;

endmodule
`default_nettype wire

/* File: src/wsw_wdt_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module wsw_wdt_counter
	import wsw_pkg::*;
#(
	parameter int WDT_TICKS = WSW_WDT_TICKS
)(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       rcTick,
	input  wire logic       fuseEnable,
	input  wire logic       clear,
	input  wire logic       psaWdt,
	input  wire logic [2:0] psRatio,
	// Expiry
	output var  logic       expire
);

	typedef struct packed {
		logic [WSW_CNT_W-1:0] baseCnt;
		logic [6:0]           preCnt;
		logic                 expire;
	} wsw_wdt_t;

	localparam logic [WSW_CNT_W-1:0] LAST = WSW_CNT_W'(WDT_TICKS - 1);
	localparam logic [WSW_CNT_W-1:0] ONE  = WSW_CNT_W'(1);

	wsw_wdt_t s;
	wsw_wdt_t next_s;

	// Base count of one nominal period, then the optional prescaler
	always_comb begin
		next_s        = s;
		next_s.expire = 1'b0;
		if (!fuseEnable || clear) begin
			next_s.baseCnt = '0;
			next_s.preCnt  = 7'h00;
		end else if (rcTick) begin
			if (s.baseCnt == LAST) begin
				next_s.baseCnt = '0;
				if (!psaWdt || s.preCnt == wsw_ratio_mask(psRatio)) begin
					next_s.preCnt = 7'h00;
					next_s.expire = 1'b1;
				end else begin
					next_s.preCnt = s.preCnt + 7'h01;
				end
			end else begin
				next_s.baseCnt = s.baseCnt + ONE;
			end
		end
		if (sys_rst) begin
			next_s = '0;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		s <= next_s;
	end

	assign expire = s.expire;

	// ************************************************************
	// Checks
	// ************************************************************
	clear_counts_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clear |=> (s.baseCnt == '0) && (s.preCnt == 7'h00) && !expire)
		else $error("watchdog counts not cleared");
	fuse_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!fuseEnable |=> !expire && (s.baseCnt == '0))
		else $error("watchdog expired while fused off");
	base_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(rcTick && fuseEnable && !clear && !psaWdt && s.baseCnt == LAST) |=> expire)
		else $error("watchdog missed the end of its period");

endmodule
`default_nettype wire

/* File: bench/wsw_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module wsw_core_model
	import wsw_pkg::*;
#(
	parameter int RETIRE_LAT = 3
)(
	// Clock
	input  wire logic          sys_clk,
	// Commands from the bench
	input  wire logic          doClr,
	input  wire logic          doSleep,
	// Core side
	input  wire wsw_core_rsp_t coreRsp,
	output var  wsw_core_req_t coreReq
);
	int waitCnt;

	// ************************************************************
	// Instruction stream
	// ************************************************************
	initial begin
		coreReq = '0;
		coreReq.pc = 13'h0123;
		waitCnt = 0;
	end

	// Retire late on purpose, so an early vector would show
	always @(posedge sys_clk) begin
		coreReq.watchdog_clear_instr <= doClr;
		coreReq.sleepInstr <= doSleep;
		coreReq.instrRetire <= (waitCnt == 1);
		if (coreRsp.wakeUp === 1'b1) begin
			waitCnt <= RETIRE_LAT;
		end else if (waitCnt != 0) begin
			waitCnt <= waitCnt - 1;
		end
		if (coreRsp.irqVector === 1'b1) begin
			coreReq.pc <= coreRsp.vectorPc;
		end else if (waitCnt == 1) begin
			coreReq.pc <= coreReq.pc + 13'h0001;
		end
	end
endmodule
`default_nettype wire

/* File: bench/wsw_watchdog_sleep_wake_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module wsw_watchdog_sleep_wake_bench
	import wsw_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [15:0] a;
		logic [7:0]  d;
		logic [7:0]  q;
	} wsw_row_t;

	logic          sys_clk;
	logic          sys_rst;
	logic          masterResetN;
	logic [7:0]    cfgStrap;
	wsw_avs_req_t  avsReq;
	logic [31:0]   readdata;
	logic          waitrequest;
	wsw_core_req_t coreReq;
	wsw_core_rsp_t coreRsp;
	logic          extIrqPin;
	logic [7:0]    timerZero;
	logic [7:0]    portBPins;
	logic [6:0]    periphIrq;
	logic [7:0]    pinOut;
	logic [7:0]    pinOe;
	logic [7:0]    padOut;
	logic [7:0]    padOe;
	logic          doClr;
	logic          doSleep;
	logic [7:0]    rd;
	int            miscompares;
	int            numChecks;
	int            cycles;
	int            wdtHits;
	int            hitsBefore;
	wsw_row_t      rows [7];

	// ************************************************************
	// Design and core model
	// ************************************************************
	// Short counts: expiry after 16 cycles at ratio 1:1
	wsw_watchdog_sleep_wake #(.RC_DIV(2), .WDT_TICKS(8)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.masterResetN(masterResetN), .cfgStrap(cfgStrap), .avsReq(avsReq), .readdata(readdata),
		.waitrequest(waitrequest), .coreReq(coreReq), .coreRsp(coreRsp), .extIrqPin(extIrqPin),
		.timerZero(timerZero), .portBPins(portBPins), .periphIrq(periphIrq), .pinOut(pinOut), .pinOe(pinOe),
		.padOut(padOut), .padOe(padOe));
	wsw_core_model #(.RETIRE_LAT(3)) i_core (.sys_clk(sys_clk), .doClr(doClr), .doSleep(doSleep),
		.coreRsp(coreRsp), .coreReq(coreReq));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Cycle ceiling and count of watchdog resets
	always @(posedge sys_clk) begin
		cycles++;
		if (coreRsp.wdtReset === 1'b1) begin
			wdtHits++;
		end
		if (cycles == 6000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Avalon access: hold everything until waitrequest is seen low
	task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avsReq <= '{read: !wr, write: wr, address: a, writedata: {24'h000000, d}, byteenable: 4'hf};
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata[7:0];
		chk("waitrequest", {31'h0, waitrequest}, 32'h0);
		avsReq.read <= 1'b0;
		avsReq.write <= 1'b0;
	endtask

	task automatic rdChk(input logic [15:0] a, input logic [7:0] exp, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h0, rd}, {24'h0, exp});
	endtask

	// Early exit on a hit; a miss waits the whole window
	task automatic waitRsp(input int sel, input int lim, input logic exp, input string nm);
		logic hit;
		hit = 1'b0;
		for (int n = 0; n < lim && !hit; n++) begin
			@(posedge sys_clk);
			hit = ((sel == 0) ? coreRsp.wakeUp : (sel == 1) ? coreRsp.wdtReset : coreRsp.irqVector) === 1'b1;
		end
		chk(nm, {31'h0, hit}, {31'h0, exp});
	endtask

	task automatic cmd(input logic slp);
		@(posedge sys_clk);
		if (slp) doSleep <= 1'b1; else doClr <= 1'b1;
		@(posedge sys_clk);
		doSleep <= 1'b0;
		doClr <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic pin(input logic v);
		@(posedge sys_clk);
		extIrqPin <= v;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic doReset(input logic [7:0] strap);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		cfgStrap <= strap;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{sys_rst, masterResetN, extIrqPin, doClr, doSleep} = 5'b11000;
		{cfgStrap, timerZero, portBPins, pinOut, pinOe} = {8'h07, 8'h00, 8'h00, 8'h5a, 8'hf0};
		avsReq = '0;
		periphIrq = 7'h00;
		{miscompares, numChecks, cycles, wdtHits} = '0;
		rows = '{'{1'b0, 16'h000c, 8'h00, 8'h18}, '{1'b0, 16'h002c, 8'h00, 8'h00}, '{1'b0, 16'h0204, 8'h00, 8'hff},
			'{1'b0, 16'h801c, 8'h00, 8'h07}, '{1'b1, 16'h000c, 8'h00, 8'h00}, '{1'b0, 16'h000c, 8'h00, 8'h18},
			'{1'b0, 16'h0100, 8'h00, 8'h00}};
		doReset(8'h07);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("register row", {24'h0, rd}, {24'h0, rows[i].q});
		end
		$display("register table done");
		pin(1'b1);
		rdChk(16'h002c, 8'h02, "rising edge");
		bus(1'b1, 16'h0204, 8'hbf);
		bus(1'b1, 16'h002c, 8'h00);
		pin(1'b0);
		rdChk(16'h002c, 8'h02, "falling edge");
		bus(1'b1, 16'h002c, 8'h00);
		pin(1'b1);
		rdChk(16'h002c, 8'h00, "wrong edge");
		timerZero <= 8'hff;
		@(posedge sys_clk);
		timerZero <= 8'h00;
		portBPins <= 8'h01;
		rdChk(16'h002c, 8'h04, "timer rollover");
		portBPins <= 8'h21;
		rdChk(16'h002c, 8'h05, "port change");
		bus(1'b1, 16'h002c, 8'h90);
		@(posedge sys_clk);
		extIrqPin <= 1'b0;
		waitRsp(2, 6, 1'b1, "vector");
		chk("return pc", {19'h0, coreRsp.returnPc}, 32'h0123);
		chk("push and vector", {18'h0, coreRsp.stackPush, coreRsp.vectorPc}, 32'h2004);
		rdChk(16'h002c, 8'h12, "global cleared");
		cmd(1'b1);
		chk("sleep no-op", {31'h0, coreRsp.sleeping}, 32'h0);
		rdChk(16'h000c, 8'h18, "no-op status");
		$display("interrupt tests done");
		bus(1'b1, 16'h002c, 8'h10);
		pin(1'b1);
		cmd(1'b1);
		chk("osc off", {31'h0, coreRsp.oscEnable}, 32'h0);
		rdChk(16'h000c, 8'h10, "sleep status");
		pinOut <= 8'ha5;
		repeat (2) @(posedge sys_clk);
		chk("pads held", {16'h0, padOut, padOe}, 32'h5af0);
		@(posedge sys_clk);
		extIrqPin <= 1'b0;
		waitRsp(0, 8, 1'b1, "irq wake");
		waitRsp(2, 10, 1'b0, "no vector");
		chk("pads follow", {24'h0, padOut}, 32'h00a5);
		// Sleep-capable peripheral wakes; with global enable set the vector follows the prefetched instruction
		bus(1'b1, 16'h002c, 8'hc0);
		cmd(1'b1);
		periphIrq <= 7'h04;
		waitRsp(0, 8, 1'b1, "peripheral wake");
		waitRsp(2, 10, 1'b1, "vector after wake");
		periphIrq <= 7'h00;
		bus(1'b1, 16'h002c, 8'h00);
		cmd(1'b0);
		bus(1'b1, 16'h0204, 8'hb1);
		hitsBefore = wdtHits;
		cmd(1'b1);
		waitRsp(0, 40, 1'b1, "watchdog wake");
		cmd(1'b0);
		rdChk(16'h000c, 8'h00, "wake status");
		repeat (6) cmd(1'b0);
		rdChk(16'h0204, 8'hb1, "option kept");
		chk("cleared in time", wdtHits, hitsBefore);
		waitRsp(1, 40, 1'b1, "watchdog reset");
		rdChk(16'h000c, 8'h08, "reset status");
		rdChk(16'h0204, 8'hff, "option reset");
		$display("watchdog tests done");
		cmd(1'b1);
		@(posedge sys_clk);
		masterResetN <= 1'b0;
		@(posedge sys_clk);
		masterResetN <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("reset exits sleep", {30'h0, coreRsp.sleeping, coreRsp.oscEnable}, 32'h1);
		rdChk(16'h000c, 8'h10, "status kept");
		doReset(8'h03);
		rdChk(16'h801c, 8'h03, "fuse off");
		bus(1'b1, 16'h0204, 8'hb8);
		hitsBefore = wdtHits;
		repeat (80) @(posedge sys_clk);
		chk("never expires", wdtHits, hitsBefore);
		$display("reset tests done");
		final_report();
	end
endmodule
`default_nettype wire
